/* hw/pcsr_top.sv */
// Power control and timer control registers of the core's special register space.
// Assumes a core on the same clock issuing one-cycle byte and bit strobes, a reset controller
// issuing synchronous reset-type pulses, and an asynchronous supply comparator output.
//
// Operation
// - Special registers decode only in 80h to FFh.
// - Timer control register is bit addressable.
// - Power bits 3 and 2 are enables.
// - Stop bit writes need timed access unlock.
// - Power control at 87h, fixed bit order.
// - Baud double output, cleared by any reset.
// - Power-on flag cleared at power-on, protected writes.
// - Fail warning sets when low, read clears.
// - Fail warning cleared at power-on, not writable.
// - Watchdog flag sets on timeout, read clears.
// - Watchdog flag set/cleared by reset type.
// - Fail interrupt enable, any reset clears it.
// - Watchdog enable protected, cleared only cold.
// - Stop request halts, any reset clears it.
// - Idle halts, cleared by interrupt or reset.
// - Timer control at 88h, fixed bit order.
`timescale 1ns/1ps
`include "pcsr_defs.svh"

module pcsr_top #(
	parameter int TA_OPEN_CYCLES = `PCSR_TA_OPEN_CYCLES
) (
	input  wire logic                         clock_in,
	input  wire logic                         sys_rst_in,
	input  wire pcsr_pkg::pcsr_sfr_req_t      sfr_req_in,
	input  wire pcsr_pkg::pcsr_reset_cause_t  reset_cause_in,
	input  wire logic                         vcc_low_in,
	input  wire logic                         wdt_timeout_in,
	input  wire logic                         irq_taken_in,
	input  wire pcsr_pkg::pcsr_timer_control_event_t   timer_control_set_in,
	input  wire pcsr_pkg::pcsr_timer_control_event_t   timer_control_ack_in,
	output logic [7:0]                        rd_data_out,
	output logic                              rd_valid_out,
	output logic                              bit_rd_data_out,
	output logic                              baud_double_out,
	output logic                              power_fail_irq_enable_out,
	output logic                              power_fail_irq_req_out,
	output logic                              watchdog_enable_out,
	output logic                              stop_mode_out,
	output logic                              idle_mode_out,
	output pcsr_pkg::pcsr_timer_ctrl_t        timer_ctrl_out
);

	pcsr_pkg::pcsr_power_ctrl_t power_ctrl_reg;
	pcsr_pkg::pcsr_power_ctrl_t power_ctrl_next;
	pcsr_pkg::pcsr_timer_ctrl_t timer_ctrl_reg;
	pcsr_pkg::pcsr_timer_ctrl_t timer_ctrl_next;
	logic [7:0]                 rd_data_reg;
	logic                       rd_valid_reg;
	logic                       bit_rd_data_reg;
	logic                       fail_irq_req_reg;
	logic                       vcc_low_meta_reg;
	logic                       vcc_low_sync_reg;
	logic                       unlock;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// special register space
	wire in_space     = sfr_req_in.addr[`PCSR_SPACE_BIT];
	wire bit_in_space = sfr_req_in.bit_addr[`PCSR_SPACE_BIT];

	wire sel_power    = in_space && (sfr_req_in.addr == `PCSR_ADDR_POWER_CTRL);
	wire sel_timer    = in_space && (sfr_req_in.addr == `PCSR_ADDR_TIMER_CTRL);
	wire sel_ta       = in_space && (sfr_req_in.addr == `PCSR_ADDR_TIMED_ACCESS);

	wire [7:0] bit_byte  = sfr_req_in.bit_addr & `PCSR_BYTE_OF_BIT_MASK;
	wire [2:0] bit_index = sfr_req_in.bit_addr[2:0];
	wire bit_sel_timer   = bit_in_space && (bit_byte == `PCSR_ADDR_TIMER_CTRL);

	wire power_wr   = sfr_req_in.wr_en && sel_power;
	wire power_rd   = sfr_req_in.rd_en && sel_power;
	wire timer_wr   = sfr_req_in.wr_en && sel_timer;
	wire timer_bwr  = sfr_req_in.bit_wr_en && bit_sel_timer;
	wire ta_wr      = sfr_req_in.wr_en && sel_ta;

	wire any_reset  = reset_cause_in.power_on || reset_cause_in.watchdog || reset_cause_in.other;

	// ****************************************************************
	// Supply comparator synchroniser
	// ****************************************************************
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			vcc_low_meta_reg <= 1'b0;
			vcc_low_sync_reg <= 1'b0;
		end else begin
			vcc_low_meta_reg <= vcc_low_in;
			vcc_low_sync_reg <= vcc_low_meta_reg;
		end
	end

	// ****************************************************************
	// Timed access unlock
	// ****************************************************************
	// two-key unlock sequence
	pcsr_timed_access #(
		.OPEN_CYCLES (TA_OPEN_CYCLES)
	) u_timed_access (
		.clock_in           (clock_in),
		.sys_rst_in         (sys_rst_in),
		.soft_reset_in      (any_reset),
		.ta_write_in        (ta_wr),
		.ta_data_in         (sfr_req_in.wr_data),
		.protected_write_in (power_wr),
		.unlock_out         (unlock)
	);

	// protected lanes open only when unlocked
	wire [7:0] protect_lanes = unlock ? `PCSR_PC_PROTECT_MASK : 8'h00;
	wire [7:0] write_lanes   = power_wr ? (`PCSR_PC_FREE_MASK | protect_lanes) : 8'h00;

	wire [7:0] power_merged  = (power_ctrl_reg & ~write_lanes) | (sfr_req_in.wr_data & write_lanes);

	// ****************************************************************
	// Power control next value
	// ****************************************************************
	always_comb begin
		power_ctrl_next = pcsr_pkg::pcsr_power_ctrl_t'(power_merged);
		power_ctrl_next.power_fail_warning = (power_ctrl_reg.power_fail_warning && !power_rd) || vcc_low_sync_reg;
		power_ctrl_next.watchdog_reset_flag = (power_ctrl_reg.watchdog_reset_flag && !power_rd) || wdt_timeout_in;
		if (irq_taken_in) begin
			power_ctrl_next.idle_request = 1'b0;
		end
		if (any_reset) begin
			power_ctrl_next.baud_double = 1'b0;
			power_ctrl_next.power_fail_irq_enable = 1'b0;
			power_ctrl_next.stop_request = 1'b0;
			power_ctrl_next.idle_request = 1'b0;
		end
		if (reset_cause_in.power_on) begin
			power_ctrl_next.power_on_flag = 1'b0;
			power_ctrl_next.power_fail_warning = 1'b0;
			power_ctrl_next.watchdog_reset_flag = 1'b0;
		end
		if (reset_cause_in.watchdog) begin
			power_ctrl_next.watchdog_reset_flag = 1'b1;
		end
	end

	// ****************************************************************
	// Timer control next value
	// ****************************************************************
	// Hardware sets follow acknowledges and writes, before the reset pulse, so an event in the cycle of its
	// acknowledge or of a software write is never lost.
	always_comb begin
		logic [7:0] t;
		t = timer_ctrl_reg;
		if (timer_wr) begin
			t = sfr_req_in.wr_data;
		end
		if (timer_bwr) begin
			t[bit_index] = sfr_req_in.bit_val;
		end
		if (timer_control_ack_in.t1_overflow) begin
			t[`PCSR_TC_T1_OVERFLOW] = 1'b0;
		end
		if (timer_control_ack_in.t0_overflow) begin
			t[`PCSR_TC_T0_OVERFLOW] = 1'b0;
		end
		// Level-triggered external flags follow the pin, so only edge mode clears on acknowledge.
		if (timer_control_ack_in.ext1_flag && timer_ctrl_reg.ext1_type) begin
			t[`PCSR_TC_EXT1_FLAG] = 1'b0;
		end
		if (timer_control_ack_in.ext0_flag && timer_ctrl_reg.ext0_type) begin
			t[`PCSR_TC_EXT0_FLAG] = 1'b0;
		end
		if (timer_control_set_in.t1_overflow) begin
			t[`PCSR_TC_T1_OVERFLOW] = 1'b1;
		end
		if (timer_control_set_in.t0_overflow) begin
			t[`PCSR_TC_T0_OVERFLOW] = 1'b1;
		end
		if (timer_control_set_in.ext1_flag) begin
			t[`PCSR_TC_EXT1_FLAG] = 1'b1;
		end
		if (timer_control_set_in.ext0_flag) begin
			t[`PCSR_TC_EXT0_FLAG] = 1'b1;
		end
		if (any_reset) begin
			t = `PCSR_TIMER_CTRL_RESET;
		end
		timer_ctrl_next = pcsr_pkg::pcsr_timer_ctrl_t'(t);
	end

	// ****************************************************************
	// Read data select
	// ****************************************************************
	wire [7:0] rd_mux = sel_power ? power_ctrl_reg :
	                    sel_timer ? timer_ctrl_reg :
	                    `PCSR_READ_UNMAPPED;
	wire [7:0] timer_bits = timer_ctrl_reg;
	wire       bit_mux    = bit_sel_timer ? timer_bits[bit_index] : 1'b0;

	// ****************************************************************
	// Registers
	// ****************************************************************
	// only the cold reset clears the watchdog enable
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			power_ctrl_reg <= pcsr_pkg::pcsr_power_ctrl_t'(`PCSR_POWER_CTRL_RESET);
			timer_ctrl_reg <= pcsr_pkg::pcsr_timer_ctrl_t'(`PCSR_TIMER_CTRL_RESET);
		end else begin
			power_ctrl_reg <= power_ctrl_next;
			timer_ctrl_reg <= timer_ctrl_next;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_reg     <= 8'h00;
			rd_valid_reg    <= 1'b0;
			bit_rd_data_reg <= 1'b0;
		end else begin
			rd_valid_reg <= sfr_req_in.rd_en;
			if (sfr_req_in.rd_en) begin
				rd_data_reg <= rd_mux;
			end
			if (sfr_req_in.bit_rd_en) begin
				bit_rd_data_reg <= bit_mux;
			end
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			fail_irq_req_reg <= 1'b0;
		end else begin
			fail_irq_req_reg <= power_ctrl_next.power_fail_warning && power_ctrl_next.power_fail_irq_enable;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rd_data_out               = rd_data_reg;
	assign rd_valid_out              = rd_valid_reg;
	assign bit_rd_data_out           = bit_rd_data_reg;
	assign baud_double_out           = power_ctrl_reg.baud_double;
	// enables in bits 3 and 2
	assign power_fail_irq_enable_out = power_ctrl_reg.power_fail_irq_enable;
	assign power_fail_irq_req_out    = fail_irq_req_reg;
	assign watchdog_enable_out       = power_ctrl_reg.watchdog_enable;
	assign stop_mode_out             = power_ctrl_reg.stop_request;
	assign idle_mode_out             = power_ctrl_reg.idle_request;
	assign timer_ctrl_out            = timer_ctrl_reg;

endmodule : pcsr_top

/* hw/pcsr_defs.svh */
// Constants of the power control and status register bank: addresses, bit positions, masks and reset values.
// Assumes nothing of its surroundings; it is included by the design modules, not by the package.
`ifndef PCSR_DEFS_SVH
`define PCSR_DEFS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PCSR_ADDR_POWER_CTRL   8'h87
`define PCSR_ADDR_TIMER_CTRL   8'h88
`define PCSR_ADDR_TIMED_ACCESS 8'hc7
`define PCSR_SPACE_BIT         7
`define PCSR_BYTE_OF_BIT_MASK  8'hf8

// ****************************************************************
// Power control bit positions and masks
// ****************************************************************
`define PCSR_PC_BAUD_DOUBLE    7
`define PCSR_PC_POWER_ON       6
`define PCSR_PC_FAIL_WARN      5
`define PCSR_PC_WDT_RESET      4
`define PCSR_PC_FAIL_IRQ_EN    3
`define PCSR_PC_WDT_ENABLE     2
`define PCSR_PC_STOP           1
`define PCSR_PC_IDLE           0
`define PCSR_PC_FREE_MASK      8'h89
`define PCSR_PC_PROTECT_MASK   8'h46

// ****************************************************************
// Timer control bit positions
// ****************************************************************
`define PCSR_TC_T1_OVERFLOW    7
`define PCSR_TC_T1_RUN         6
`define PCSR_TC_T0_OVERFLOW    5
`define PCSR_TC_T0_RUN         4
`define PCSR_TC_EXT1_FLAG      3
`define PCSR_TC_EXT1_TYPE      2
`define PCSR_TC_EXT0_FLAG      1
`define PCSR_TC_EXT0_TYPE      0

// ****************************************************************
// Reset values, keys and timing
// ****************************************************************
`define PCSR_POWER_CTRL_RESET  8'h00
`define PCSR_TIMER_CTRL_RESET  8'h00
`define PCSR_READ_UNMAPPED     8'h00
`define PCSR_TA_KEY_FIRST      8'haa
`define PCSR_TA_KEY_SECOND     8'h55
`define PCSR_TA_OPEN_CYCLES    4

`endif

/* hw/pcsr_pkg.sv */
// Types shared by the power control and status register bank.
// Assumes nothing of its surroundings; it uses none of the constants header.
package pcsr_pkg;

	// ****************************************************************
	// Bus request from the core
	// ****************************************************************
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
		logic       bit_wr_en;
		logic       bit_rd_en;
		logic [7:0] bit_addr;
		logic       bit_val;
	} pcsr_sfr_req_t;

	// Synchronous reset-type pulses from the reset controller.
	typedef struct packed {
		logic power_on;
		logic watchdog;
		logic other;
	} pcsr_reset_cause_t;

	// Hardware set or clear pulses for the timer control flags.
	typedef struct packed {
		logic t1_overflow;
		logic t0_overflow;
		logic ext1_flag;
		logic ext0_flag;
	} pcsr_timer_control_event_t;

	// ****************************************************************
	// Register layouts, bit 7 first
	// ****************************************************************
	typedef struct packed {
		logic baud_double;
		logic power_on_flag;
		logic power_fail_warning;
		logic watchdog_reset_flag;
		logic power_fail_irq_enable;
		logic watchdog_enable;
		logic stop_request;
		logic idle_request;
	} pcsr_power_ctrl_t;

	typedef struct packed {
		logic t1_overflow;
		logic t1_run;
		logic t0_overflow;
		logic t0_run;
		logic ext1_flag;
		logic ext1_type;
		logic ext0_flag;
		logic ext0_type;
	} pcsr_timer_ctrl_t;

	typedef enum logic [2:0] {
		PCSR_TA_LOCKED = 3'b001,
		PCSR_TA_ARMED  = 3'b010,
		PCSR_TA_OPEN   = 3'b100
	} pcsr_ta_state_t;

endpackage : pcsr_pkg

/* hw/pcsr_timed_access.sv */
// Timed access unlock sequencer for protected register bits.
// Assumes writes to the timed access address arrive as one-cycle strobes on the same clock.
`timescale 1ns/1ps
`include "pcsr_defs.svh"

module pcsr_timed_access #(
	parameter int OPEN_CYCLES = `PCSR_TA_OPEN_CYCLES
) (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	input  wire logic       soft_reset_in,
	input  wire logic       ta_write_in,
	input  wire logic [7:0] ta_data_in,
	input  wire logic       protected_write_in,
	output logic            unlock_out
);

	localparam int CW = $clog2(OPEN_CYCLES + 1);

	if (OPEN_CYCLES < 1) begin : g_bad_open
		$error("OPEN_CYCLES must be at least one");
	end

	pcsr_pkg::pcsr_ta_state_t state_reg;
	pcsr_pkg::pcsr_ta_state_t state_next;
	logic [CW-1:0]            count_reg;
	logic [CW-1:0]            count_next;

	wire key_first  = ta_write_in && (ta_data_in == `PCSR_TA_KEY_FIRST);
	wire key_second = ta_write_in && (ta_data_in == `PCSR_TA_KEY_SECOND);
	wire expired    = (count_reg == CW'(OPEN_CYCLES - 1));

	// ****************************************************************
	// Sequence of the two keys
	// ****************************************************************
	// A stray value breaks the sequence, so a runaway loop that writes the
	// timed access address cannot stumble into the open state.
	always_comb begin
		state_next = state_reg;
		count_next = count_reg + CW'(1);
		case (state_reg)
			pcsr_pkg::PCSR_TA_LOCKED: begin
				count_next = '0;
				if (key_first) begin
					state_next = pcsr_pkg::PCSR_TA_ARMED;
				end
			end
			pcsr_pkg::PCSR_TA_ARMED: begin
				if (key_second) begin
					state_next = pcsr_pkg::PCSR_TA_OPEN;
					count_next = '0;
				end else if (key_first) begin
					count_next = '0;
				end else if (ta_write_in || expired) begin
					state_next = pcsr_pkg::PCSR_TA_LOCKED;
				end
			end
			pcsr_pkg::PCSR_TA_OPEN: begin
				if (protected_write_in) begin
					state_next = pcsr_pkg::PCSR_TA_LOCKED;
				end else if (key_first) begin
					state_next = pcsr_pkg::PCSR_TA_ARMED;
					count_next = '0;
				end else if (ta_write_in || expired) begin
					state_next = pcsr_pkg::PCSR_TA_LOCKED;
				end
			end
			default: begin
				state_next = pcsr_pkg::PCSR_TA_LOCKED;
				count_next = '0;
			end
		endcase
		if (soft_reset_in) begin
			state_next = pcsr_pkg::PCSR_TA_LOCKED;
			count_next = '0;
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= pcsr_pkg::PCSR_TA_LOCKED;
			count_reg <= '0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	assign unlock_out = (state_reg == pcsr_pkg::PCSR_TA_OPEN);

endmodule : pcsr_timed_access

/* testbench/pcsr_monitor.sv */
// Concurrent checks on the ports of the power control register bank.
// Assumes the bank package is compiled first; bound to every pcsr_top.
`timescale 1ns/1ps

module pcsr_monitor #(
	parameter int TA_OPEN_CYCLES = 4
) (
	input wire logic                        clock_in,
	input wire logic                        sys_rst_in,
	input wire pcsr_pkg::pcsr_sfr_req_t     sfr_req_in,
	input wire pcsr_pkg::pcsr_reset_cause_t reset_cause_in,
	input wire logic                        vcc_low_in,
	input wire logic                        wdt_timeout_in,
	input wire logic                        irq_taken_in,
	input wire pcsr_pkg::pcsr_timer_control_event_t  timer_control_set_in,
	input wire pcsr_pkg::pcsr_timer_control_event_t  timer_control_ack_in,
	input wire logic [7:0]                  rd_data_out,
	input wire logic                        rd_valid_out,
	input wire logic                        bit_rd_data_out,
	input wire logic                        baud_double_out,
	input wire logic                        power_fail_irq_enable_out,
	input wire logic                        power_fail_irq_req_out,
	input wire logic                        watchdog_enable_out,
	input wire logic                        stop_mode_out,
	input wire logic                        idle_mode_out,
	input wire pcsr_pkg::pcsr_timer_ctrl_t  timer_ctrl_out
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);

	// ********
	// Helper logic
	// ********
	// Cycles since the last key write; saturates so old keys never look fresh.
	logic [7:0] ta_age_reg;
	wire        wr_pc   = sfr_req_in.wr_en && sfr_req_in.addr == 8'h87;
	wire        rd_pc   = sfr_req_in.rd_en && sfr_req_in.addr == 8'h87;
	wire        any_rst = |reset_cause_in;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			ta_age_reg <= 8'hff;
		else if (sfr_req_in.wr_en && sfr_req_in.addr == 8'hc7)
			ta_age_reg <= 8'h00;
		else if (ta_age_reg != 8'hff)
			ta_age_reg <= ta_age_reg + 8'h01;
	end

	// ********
	// Assertions
	// ********
	chk_unmapped_read: assert property (
		sfr_req_in.rd_en && !sfr_req_in.addr[7] |=> rd_valid_out && rd_data_out == 8'h00)
		else $error("unmapped read not answered with zero");
	chk_free_write: assert property (
		wr_pc && !any_rst |=> baud_double_out == $past(sfr_req_in.wr_data[7])
		&& power_fail_irq_enable_out == $past(sfr_req_in.wr_data[3]))
		else $error("free power bits did not take the write");
	chk_cause_clears: assert property (
		any_rst |=> !baud_double_out && !power_fail_irq_enable_out && !stop_mode_out
		&& !idle_mode_out && timer_ctrl_out == 8'h00)
		else $error("reset type pulse left a bit set");
	chk_wdt_en_keep: assert property (
		any_rst && !wr_pc |=> watchdog_enable_out == $past(watchdog_enable_out))
		else $error("watchdog enable changed on a warm reset");
	chk_wdt_flag_clear: assert property (
		rd_pc && !wdt_timeout_in && !reset_cause_in.watchdog ##1 rd_pc |=> !rd_data_out[4])
		else $error("watchdog flag survived a read");
	chk_idle_wake: assert property (
		irq_taken_in && !wr_pc |=> !idle_mode_out)
		else $error("idle not left on interrupt");
	chk_irq_gate: assert property (
		power_fail_irq_req_out |-> power_fail_irq_enable_out)
		else $error("fail request without enable");
	chk_stop_locked: assert property (
		wr_pc && ta_age_reg >= TA_OPEN_CYCLES && !any_rst
		|=> $stable(stop_mode_out) && $stable(watchdog_enable_out))
		else $error("protected bit written while locked");
	chk_bit_write: assert property (
		sfr_req_in.bit_wr_en && sfr_req_in.bit_addr == 8'h8e && !sfr_req_in.wr_en && !any_rst
		|=> timer_ctrl_out.t1_run == $past(sfr_req_in.bit_val))
		else $error("bit write to timer run missed");

	cov_unlocked_write: cover property (wr_pc && ta_age_reg < 8'h02);
	cov_double_read: cover property (rd_pc ##1 rd_pc);
	cov_fail_request: cover property (power_fail_irq_req_out);
endmodule : pcsr_monitor

bind pcsr_top pcsr_monitor #(.TA_OPEN_CYCLES(TA_OPEN_CYCLES)) i_monitor (
	.clock_in(clock_in), .sys_rst_in(sys_rst_in), .sfr_req_in(sfr_req_in),
	.reset_cause_in(reset_cause_in), .vcc_low_in(vcc_low_in), .wdt_timeout_in(wdt_timeout_in),
	.irq_taken_in(irq_taken_in), .timer_control_set_in(timer_control_set_in), .timer_control_ack_in(timer_control_ack_in),
	.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .bit_rd_data_out(bit_rd_data_out),
	.baud_double_out(baud_double_out), .power_fail_irq_enable_out(power_fail_irq_enable_out),
	.power_fail_irq_req_out(power_fail_irq_req_out), .watchdog_enable_out(watchdog_enable_out),
	.stop_mode_out(stop_mode_out), .idle_mode_out(idle_mode_out), .timer_ctrl_out(timer_ctrl_out));

/* testbench/power_control_status_register_tb.sv */
// Self-checking bench of the power control register bank.
// Assumes the package, the design and the monitor are compiled before it.
`timescale 1ns/1ps

module power_control_status_register_tb;
	logic                        clock_in       = 1'b0;
	logic                        sys_rst_in     = 1'b1;
	pcsr_pkg::pcsr_sfr_req_t     sfr_req        = '0;
	pcsr_pkg::pcsr_reset_cause_t reset_cause_in = '0;
	logic                        vcc_low_in     = 1'b0;
	logic                        wdt_timeout_in = 1'b0;
	logic                        irq_taken_in   = 1'b0;
	pcsr_pkg::pcsr_timer_control_event_t  timer_control_set_in    = '0;
	pcsr_pkg::pcsr_timer_control_event_t  timer_control_ack_in    = '0;
	logic [7:0]                  rd_data_out;
	logic                        rd_valid_out;
	logic                        bit_rd_data_out;
	logic                        baud_out;
	logic                        irq_en_out;
	logic                        irq_req_out;
	logic                        wdt_en_out;
	logic                        stop_out;
	logic                        idle_out;
	pcsr_pkg::pcsr_timer_ctrl_t  timer_ctrl_out;
	int                          bad_count      = 0;
	int                          n_checks       = 0;

	always #2.5 clock_in = ~clock_in;

	pcsr_top i_dut (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in), .sfr_req_in(sfr_req),
		.reset_cause_in(reset_cause_in), .vcc_low_in(vcc_low_in), .wdt_timeout_in(wdt_timeout_in),
		.irq_taken_in(irq_taken_in), .timer_control_set_in(timer_control_set_in), .timer_control_ack_in(timer_control_ack_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .bit_rd_data_out(bit_rd_data_out),
		.baud_double_out(baud_out), .power_fail_irq_enable_out(irq_en_out),
		.power_fail_irq_req_out(irq_req_out), .watchdog_enable_out(wdt_en_out),
		.stop_mode_out(stop_out), .idle_mode_out(idle_out), .timer_ctrl_out(timer_ctrl_out));

	// ********
	// Tasks
	// ********
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic step();
		@(posedge clock_in);
		#1;
	endtask : step

	// Every request stands for exactly one sampling edge, then the bus goes idle.
	task automatic access(input pcsr_pkg::pcsr_sfr_req_t r);
		step();
		sfr_req = r;
		step();
		sfr_req = '0;
	endtask : access

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access('{wr_en: 1'b1, addr: a, wr_data: d, default: '0});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		access('{rd_en: 1'b1, addr: a, default: '0});
		check("rd_valid", {7'h00, rd_valid_out}, 8'h01);
		check("rd_data", rd_data_out, exp);
	endtask : rd

	// Two reads on consecutive edges; the second sees what the first left behind.
	task automatic rd_pair(input logic [7:0] a, input logic [7:0] exp1, input logic [7:0] exp2);
		step();
		sfr_req = '{rd_en: 1'b1, addr: a, default: '0};
		step();
		check("rd_data first", rd_data_out, exp1);
		step();
		sfr_req = '0;
		check("rd_valid", {7'h00, rd_valid_out}, 8'h01);
		check("rd_data second", rd_data_out, exp2);
	endtask : rd_pair

	task automatic bit_access(input logic rd_n_wr, input logic [7:0] a, input logic v);
		access('{bit_rd_en: rd_n_wr, bit_wr_en: !rd_n_wr, bit_addr: a, bit_val: v, default: '0});
	endtask : bit_access

	task automatic events(input logic [2:0] c, input logic w, input logic i, input logic [7:0] sa);
		step();
		reset_cause_in = c;
		wdt_timeout_in = w;
		irq_taken_in = i;
		{timer_control_set_in, timer_control_ack_in} = sa;
		step();
		reset_cause_in = '0;
		{wdt_timeout_in, irq_taken_in} = 2'b00;
		{timer_control_set_in, timer_control_ack_in} = 8'h00;
	endtask : events

	// Packs baud, fail enable, fail request, watchdog enable, stop and idle.
	task automatic outs(input logic [7:0] exp);
		check("mode outputs", {2'b00, baud_out, irq_en_out, irq_req_out, wdt_en_out, stop_out, idle_out}, exp);
	endtask : outs

	// ********
	// Sequence
	// ********
	initial begin
		repeat (6) @(posedge clock_in);
		#1;
		sys_rst_in = 1'b0;
		outs(8'h00);
		rd(8'h87, 8'h00);
		rd(8'h88, 8'h00);
		wr(8'h87, 8'hff);
		rd(8'h87, 8'h89);
		outs(8'h31);
		wr(8'hc7, 8'haa);
		wr(8'hc7, 8'h55);
		wr(8'h87, 8'h46);
		outs(8'h06);
		wr(8'h87, 8'h00);
		rd(8'h87, 8'h46);
		events(3'b001, 1'b0, 1'b0, 8'h00);
		outs(8'h04);
		rd(8'h87, 8'h44);
		events(3'b000, 1'b1, 1'b0, 8'h00);
		rd(8'h87, 8'h54);
		rd(8'h87, 8'h44);
		events(3'b010, 1'b0, 1'b0, 8'h00);
		rd_pair(8'h87, 8'h54, 8'h44);
		events(3'b100, 1'b0, 1'b0, 8'h00);
		rd(8'h87, 8'h04);
		wr(8'h87, 8'h08);
		vcc_low_in = 1'b1;
		repeat (4) step();
		outs(8'h1c);
		rd(8'h87, 8'h2c);
		rd(8'h87, 8'h2c);
		vcc_low_in = 1'b0;
		repeat (4) step();
		rd(8'h87, 8'h2c);
		rd(8'h87, 8'h0c);
		outs(8'h14);
		wr(8'h87, 8'h01);
		outs(8'h05);
		events(3'b000, 1'b0, 1'b1, 8'h00);
		outs(8'h04);
		// A late second key must not open the protected bits.
		wr(8'hc7, 8'haa);
		repeat (6) step();
		wr(8'hc7, 8'h55);
		wr(8'h87, 8'h02);
		outs(8'h04);
		rd(8'h40, 8'h00);
		rd(8'hc7, 8'h00);
		wr(8'h88, 8'ha5);
		check("timer ctrl", timer_ctrl_out, 8'ha5);
		bit_access(1'b0, 8'h8e, 1'b1);
		bit_access(1'b1, 8'h8e, 1'b0);
		check("bit read", {7'h00, bit_rd_data_out}, 8'h01);
		rd(8'h88, 8'he5);
		events(3'b000, 1'b0, 1'b0, 8'h28);
		check("timer ctrl", timer_ctrl_out, 8'h6d);
		events(3'b000, 1'b0, 1'b0, 8'h02);
		check("timer ctrl", timer_ctrl_out, 8'h65);
		wr(8'h88, 8'h0a);
		events(3'b000, 1'b0, 1'b0, 8'h03);
		check("timer ctrl", timer_ctrl_out, 8'h0a);
		events(3'b001, 1'b0, 1'b0, 8'h00);
		check("timer ctrl", timer_ctrl_out, 8'h00);
		sys_rst_in = 1'b1;
		step();
		sys_rst_in = 1'b0;
		outs(8'h00);
		finish_test();
	end

	initial begin
		repeat (5000) @(posedge clock_in);
		bad_count++;
		finish_test();
	end
endmodule : power_control_status_register_tb
